// File: src/dslp_dev.sv
// Purpose: device end: deep-sleep power states and health counters
// Assumes: NV_LOAD restores lifetime values once after power-on
// Notes: all state frozen while CE is low
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module dslp_dev
	import dslp_pkg::*;
#(
	parameter int MS_CYC = CYC_PER_MS,
	parameter int HOUR_LEN_MS = HOUR_MS
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	dslp_if.dev LNK,
	input wire logic DIPM_EN,
	input wire logic BLOCK_RETIRE,
	input wire logic NV_LOAD,
	input wire logic [31:0] NV_HOURS,
	input wire logic [31:0] NV_CYCLES,
	input wire logic [31:0] NV_RETIRED,
	output logic [31:0] POWER_ON_HOURS,
	output logic [31:0] POWER_CYCLES,
	output logic [31:0] RETIRED_BLOCKS,
	output logic [2:0] SLEEP_STATE,
	output logic FEATURE_EN,
	output logic SHORT_ASSERT
);
	dslp_dstate_t st_q, st_d;
	logic feat_q, feat_d;
	logic [17:0] pre_q, pre_d;
	logic [7:0] ms_q, ms_d;
	logic short_q, short_d;
	logic tick;
	logic [17:0] poh_cyc_q, poh_cyc_d;
	logic [21:0] poh_ms_q, poh_ms_d;
	logic [31:0] hours_q, hours_d;
	logic [31:0] cycles_q, cycles_d;
	logic [31:0] retired_q, retired_d;
	logic boot_q, boot_d;
	logic countable;

	// link handshake views of the power state
	assign LNK.link_up = (st_q == D_ACTIVE);
	assign LNK.oob_ready = (st_q == D_SLUMBER) || (st_q == D_REDUCED);
	assign LNK.slumber_ack = (st_q != D_ACTIVE);
	assign LNK.min_assert_ms = MIN_ASSERT_MS;
	assign LNK.exit_to_ms = EXIT_TIMEOUT_MS;
	assign tick = (pre_q == 18'(MS_CYC - 1));

	// power state, ms timer restarted on every state change
	always_comb begin
		st_d = st_q;
		feat_d = feat_q;
		short_d = short_q;
		if (LNK.feat_set) begin
			feat_d = 1'b1;
		end else if (LNK.feat_clr) begin
			feat_d = 1'b0;
		end
		case (st_q)
			D_ACTIVE: begin
				if (LNK.slumber_req) begin
					st_d = D_SLUMBER;
				end
			end
			D_SLUMBER: begin
				// pin only honoured once enabled and from slumber
				if (LNK.comwake) begin
					st_d = D_ACTIVE;
				end else if (LNK.sleep_pin && feat_q) begin
					st_d = D_DSLEEP;
				end
			end
			D_DSLEEP: begin
				if (!LNK.sleep_pin) begin
					st_d = D_EXIT;
					if (ms_q < MIN_ASSERT_MS) begin
						short_d = 1'b1;
					end
				end
			end
			D_EXIT: begin
				// wake latency stays well inside the exit timeout
				if (tick && (ms_q + 8'h01 >= DEV_WAKE_MS)) begin
					st_d = D_REDUCED;
				end
			end
			D_REDUCED: begin
				if (LNK.comwake) begin
					st_d = D_ACTIVE;
				end
			end
			default: begin
				st_d = D_ACTIVE;
			end
		endcase
		if (st_d != st_q) begin
			pre_d = '0;
			ms_d = '0;
		end else if (tick) begin
			pre_d = '0;
			ms_d = (ms_q == 8'hFF) ? ms_q : ms_q + 8'h01;
		end else begin
			pre_d = pre_q + 18'h00001;
			ms_d = ms_q;
		end
	end

	// power state registers
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= D_ACTIVE;
			feat_q <= 1'b0;
			short_q <= 1'b0;
			pre_q <= '0;
			ms_q <= '0;
		end else if (CE) begin
			st_q <= st_d;
			feat_q <= feat_d;
			short_q <= short_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
		end
	end

	// deep sleep, exit and reduced residency are not counted as powered time; slumber is excluded only with DIPM_EN
	assign countable = !((st_q == D_DSLEEP) || (st_q == D_EXIT) ||
		(st_q == D_REDUCED) ||
		(DIPM_EN && (st_q == D_SLUMBER)));

	// lifetime counters: hours, power cycles, retired blocks
	always_comb begin
		poh_cyc_d = poh_cyc_q;
		poh_ms_d = poh_ms_q;
		hours_d = hours_q;
		cycles_d = cycles_q;
		retired_d = retired_q;
		boot_d = 1'b0;
		if (countable) begin
			if (poh_cyc_q == 18'(MS_CYC - 1)) begin
				poh_cyc_d = '0;
				if (poh_ms_q == 22'(HOUR_LEN_MS - 1)) begin
					poh_ms_d = '0;
					hours_d = hours_q + 32'h00000001;
				end else begin
					poh_ms_d = poh_ms_q + 22'h000001;
				end
			end else begin
				poh_cyc_d = poh_cyc_q + 18'h00001;
			end
		end
		if (boot_q) begin
			cycles_d = cycles_q + 32'h00000001;
		end
		if (BLOCK_RETIRE) begin
			retired_d = retired_q + 32'h00000001;
		end
		// restore wins, but a retire in the same cycle is added; it counts as this power cycle's event
		if (NV_LOAD) begin
			hours_d = NV_HOURS;
			cycles_d = NV_CYCLES + 32'h00000001;
			retired_d = NV_RETIRED + {31'h0, BLOCK_RETIRE};
		end
	end

	// counter registers; boot_q marks the first enabled cycle
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			poh_cyc_q <= '0;
			poh_ms_q <= '0;
			hours_q <= '0;
			cycles_q <= '0;
			retired_q <= '0;
			boot_q <= 1'b1;
		end else if (CE) begin
			poh_cyc_q <= poh_cyc_d;
			poh_ms_q <= poh_ms_d;
			hours_q <= hours_d;
			cycles_q <= cycles_d;
			retired_q <= retired_d;
			boot_q <= boot_d;
		end
	end

	// status outputs straight from registers
	assign POWER_ON_HOURS = hours_q;
	assign POWER_CYCLES = cycles_q;
	assign RETIRED_BLOCKS = retired_q;
	assign SLEEP_STATE = st_q;
	assign FEATURE_EN = feat_q;
	assign SHORT_ASSERT = short_q;
endmodule // dslp_dev

// File: src/dslp_host.sv
// Purpose: host end: idle timing, slumber, sleep pin and wake
// Assumes: register port with read data one cycle after the strobe
// Notes: multiplier register accepts one write after reset
`timescale 1ns/1ps
module dslp_host
	import dslp_pkg::*;
#(
	parameter int MS_CYC = CYC_PER_MS
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic CE,
	input wire logic [3:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic LINK_IDLE,
	input wire logic WAKE_REQ,
	dslp_if.host LNK
);
	dslp_hstate_t st_q, st_d;
	logic en_q, en_d;
	logic [15:0] idle_q, idle_d;
	logic [3:0] mult_q, mult_d;
	logic lock_q, lock_d;
	logic fset_q, fset_d, fclr_q, fclr_d;
	logic cw_q, cw_d;
	logic pin_q, pin_d;
	logic [31:0] rd_q, rd_d;
	logic [17:0] pre_q, pre_d;
	logic [19:0] ms_q, ms_d;
	logic [19:0] total;
	logic tick;

	assign tick = (pre_q == 18'(MS_CYC - 1));
	// idle time before slumber request: base times multiplier plus one
	assign total = {4'h0, idle_q} *
		({16'h0000, mult_q} + 20'h00001);

	// registers, feature commands and link sequencing
	always_comb begin
		en_d = en_q;
		idle_d = idle_q;
		mult_d = mult_q;
		lock_d = lock_q;
		fset_d = 1'b0;
		fclr_d = 1'b0;
		cw_d = 1'b0;
		pin_d = pin_q;
		st_d = st_q;
		rd_d = '0;
		if (WR) begin
			case (ADDR)
				A_CTRL: begin
					en_d = WDATA[CTRL_EN_BIT];
					fset_d = WDATA[CTRL_EN_BIT] && !en_q;
					fclr_d = !WDATA[CTRL_EN_BIT] && en_q;
				end
				A_IDLE: idle_d = WDATA[15:0];
				A_MULT: begin
					if (!lock_q) begin
						mult_d = WDATA[3:0];
						lock_d = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (RD) begin
			case (ADDR)
				A_CTRL: rd_d[CTRL_EN_BIT] = en_q;
				A_IDLE: rd_d[15:0] = idle_q;
				A_MULT: rd_d[3:0] = mult_q;
				A_STAT: begin
					rd_d[2:0] = st_q;
					rd_d[STAT_PIN_BIT] = pin_q;
					rd_d[STAT_LOCK_BIT] = lock_q;
					rd_d[STAT_FEAT_BIT] = en_q;
					rd_d[STAT_MIN_LSB +: 8] = LNK.min_assert_ms;
					rd_d[STAT_EXIT_LSB +: 8] = LNK.exit_to_ms;
				end
				default: ;
			endcase
		end
		case (st_q)
			H_ACT: begin
				if (LINK_IDLE && ms_q >= total) begin
					st_d = H_SLREQ;
				end
			end
			H_SLREQ: begin
				// pin only asserted once both sides sit in slumber
				if (LNK.slumber_ack) begin
					if (en_q) begin
						st_d = H_DSLP;
						pin_d = 1'b1;
					end else begin
						st_d = H_SLUMB;
					end
				end
			end
			H_SLUMB: begin
				if (WAKE_REQ) begin
					st_d = H_WAKE;
					cw_d = 1'b1;
				end
			end
			H_DSLP: begin
				if (WAKE_REQ && ms_q >= {12'h000, LNK.min_assert_ms}) begin
					st_d = H_EXIT;
					pin_d = 1'b0;
				end
			end
			H_EXIT: begin
				if (LNK.oob_ready ||
					ms_q >= {12'h000, LNK.exit_to_ms}) begin
					st_d = H_WAKE;
					cw_d = 1'b1;
				end
			end
			H_WAKE: begin
				if (LNK.link_up) begin
					st_d = H_ACT;
				end
			end
			default: begin
				st_d = H_ACT;
				pin_d = 1'b0;
			end
		endcase
		// ms timer restarts on state change or when traffic resumes
		if (st_d != st_q || (st_q == H_ACT && !LINK_IDLE)) begin
			pre_d = '0;
			ms_d = '0;
		end else if (tick) begin
			pre_d = '0;
			ms_d = (ms_q == 20'hFFFFF) ? ms_q : ms_q + 20'h00001;
		end else begin
			pre_d = pre_q + 18'h00001;
			ms_d = ms_q;
		end
	end

	// host state registers
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= H_ACT;
			en_q <= 1'b0;
			idle_q <= IDLE_MS_RST;
			mult_q <= MULT_RST;
			lock_q <= 1'b0;
			fset_q <= 1'b0;
			fclr_q <= 1'b0;
			cw_q <= 1'b0;
			pin_q <= 1'b0;
			rd_q <= '0;
			pre_q <= '0;
			ms_q <= '0;
		end else if (CE) begin
			st_q <= st_d;
			en_q <= en_d;
			idle_q <= idle_d;
			mult_q <= mult_d;
			lock_q <= lock_d;
			fset_q <= fset_d;
			fclr_q <= fclr_d;
			cw_q <= cw_d;
			pin_q <= pin_d;
			rd_q <= rd_d;
			pre_q <= pre_d;
			ms_q <= ms_d;
		end
	end

	// link drive; slumber request dropped once wake starts
	assign LNK.sleep_pin = pin_q;
	assign LNK.feat_set = fset_q;
	assign LNK.feat_clr = fclr_q;
	assign LNK.comwake = cw_q;
	assign LNK.slumber_req = (st_q == H_SLREQ) || (st_q == H_SLUMB) ||
		(st_q == H_DSLP) || (st_q == H_EXIT);
	assign RDATA = rd_q;
endmodule // dslp_host

// File: src/dslp_if.sv
// Purpose: link between host controller and device sleep logic
// Assumes: both ends on the same clock
// Notes: pulses last one enabled cycle
`timescale 1ns/1ps
interface dslp_if;
	logic sleep_pin;
	logic feat_set;
	logic feat_clr;
	logic slumber_req;
	logic slumber_ack;
	logic comwake;
	logic oob_ready;
	logic link_up;
	logic [7:0] min_assert_ms;
	logic [7:0] exit_to_ms;
	modport dev (input sleep_pin, input feat_set, input feat_clr,
		input slumber_req, input comwake, output slumber_ack,
		output oob_ready, output link_up, output min_assert_ms,
		output exit_to_ms);
	modport host (output sleep_pin, output feat_set, output feat_clr,
		output slumber_req, output comwake, input slumber_ack,
		input oob_ready, input link_up, input min_assert_ms,
		input exit_to_ms);
endinterface

// File: src/dslp_pkg.sv
// Purpose: shared constants for the deep-sleep link ends and counters
// Assumes: one 200 MHz clock, times kept in milliseconds
// Notes: Operation summary follows
// Operation
// - Sleep pin ignored until feature enabled
// - Host drives valid sleep pin levels
// - Deep sleep entered only from slumber
// - COMWAKE wakes device from reduced power
// - Host idle timeout base 375 ms
// - Host waits idle times multiplier plus one
// - Report 10 ms; host holds pin that long
// - Ready for OOB within 20 ms exit
// - Power-on hours exclude low-power residency (slumber only with DIPM_EN)
// - Count power cycles over lifetime
// - Report grown retired block count
package dslp_pkg;
	localparam int CLK_MHZ = 200;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int HOUR_MS = 3600000;
	localparam logic [7:0] MIN_ASSERT_MS = 8'h0A;
	localparam logic [7:0] EXIT_TIMEOUT_MS = 8'h14;
	localparam logic [7:0] DEV_WAKE_MS = 8'h01;
	localparam logic [15:0] IDLE_MS_RST = 16'h0177;
	localparam logic [3:0] MULT_RST = 4'hF;
	// host register map, byte addresses
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_IDLE = 4'h4;
	localparam logic [3:0] A_MULT = 4'h8;
	localparam logic [3:0] A_STAT = 4'hC;
	localparam int CTRL_EN_BIT = 0;
	localparam int STAT_PIN_BIT = 3;
	localparam int STAT_LOCK_BIT = 4;
	localparam int STAT_FEAT_BIT = 5;
	localparam int STAT_MIN_LSB = 8;
	localparam int STAT_EXIT_LSB = 16;
	typedef enum logic [2:0] {
		D_ACTIVE = 3'h0,
		D_SLUMBER = 3'h1,
		D_DSLEEP = 3'h3,
		D_EXIT = 3'h2,
		D_REDUCED = 3'h6
	} dslp_dstate_t;
	typedef enum logic [2:0] {
		H_ACT = 3'h0,
		H_SLREQ = 3'h1,
		H_SLUMB = 3'h3,
		H_DSLP = 3'h2,
		H_EXIT = 3'h6,
		H_WAKE = 3'h7
	} dslp_hstate_t;
endpackage

// File: verif/dslp_bench.sv
// Purpose: drives host registers and device inputs, checks both ends
// Assumes: ms shortened to MS cycles, hour to three ms
// Notes: read results are compared from a queue of expectations
`timescale 1ns/1ps
module dslp_bench
	import dslp_pkg::*;
;
	localparam int MS = 20;
	logic mclk = '0, rstn = '0, wr = '0, rd = '0, rd_q = '0;
	logic idle = '0, wake = '0, dipm = '0, retire = '0, nv_load = '0;
	logic ce = 1'h1;
	logic [3:0] addr = '0;
	logic [31:0] wdata = '0, nv_h = '0, nv_c = '0, nv_r = '0, rdata, h0;
	logic [31:0] hours, cycles, retired, lfsr = 32'hA0FDEBF7;
	logic [2:0] state;
	logic feat_en, short_a;
	logic [31:0] exp_q[$];
	int mismatches = 0, samples_checked = 0, n, k;
	dslp_if lnk ();
	wire [3:0] mon = {lnk.oob_ready, lnk.link_up, lnk.sleep_pin,
		lnk.slumber_ack};
	dslp_host #(.MS_CYC(MS)) i_dslp_host (.MCLK(mclk), .RSTN(rstn),
		.CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .LINK_IDLE(idle), .WAKE_REQ(wake), .LNK(lnk.host));
	dslp_dev #(.MS_CYC(MS), .HOUR_LEN_MS(3)) i_dslp_dev (.MCLK(mclk),
		.RSTN(rstn), .CE(ce), .LNK(lnk.dev), .DIPM_EN(dipm),
		.BLOCK_RETIRE(retire), .NV_LOAD(nv_load), .NV_HOURS(nv_h),
		.NV_CYCLES(nv_c), .NV_RETIRED(nv_r), .POWER_ON_HOURS(hours),
		.POWER_CYCLES(cycles), .RETIRED_BLOCKS(retired),
		.SLEEP_STATE(state), .FEATURE_EN(feat_en), .SHORT_ASSERT(short_a));
	dslp_checker #(.MS_CYC(MS)) i_dslp_checker (.MCLK(mclk), .RSTN(rstn),
		.sleep_pin(lnk.sleep_pin), .feat_set(lnk.feat_set),
		.feat_clr(lnk.feat_clr), .slumber_req(lnk.slumber_req),
		.slumber_ack(lnk.slumber_ack), .comwake(lnk.comwake),
		.oob_ready(lnk.oob_ready), .link_up(lnk.link_up),
		.min_assert_ms(lnk.min_assert_ms), .exit_to_ms(lnk.exit_to_ms));
	always #2.5 mclk = ~mclk;
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int c = 1);
		repeat (c) @(posedge mclk);
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		tick();
		wr <= 1'h0;
		tick();
	endtask
	task automatic rreg(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'h1;
		tick();
		rd <= 1'h0;
		tick();
	endtask
	// bounded wait on a link signal, counts cycles in c
	task automatic wait_for(input int s, input logic v, output int c);
		for (c = 0; mon[s] !== v; c++) begin
			if (c == 2000) begin
				mismatches++;
				final_report();
			end
			tick();
		end
	endtask
	// read data stand in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_q)
			check(rdata, exp_q.pop_front());
		rd_q <= rd;
	end
	initial begin
		tick(3);
		rstn <= 1'h1;
		tick(2);
		// reset values, reports and an unmapped place
		check(cycles, 32'h1);
		rreg(A_IDLE, {16'h0, IDLE_MS_RST});
		rreg(A_MULT, {28'h0, MULT_RST});
		rreg(A_STAT, {8'h0, EXIT_TIMEOUT_MS, MIN_ASSERT_MS, 8'h0});
		rreg(4'h2, 32'h0);
		h0 = hours;
		tick(3 * 3 * MS);
		check(hours, h0 + 3);
		// clock enable low freezes the counters
		ce <= 1'h0;
		tick();
		h0 = hours;
		tick(6 * MS);
		check(hours, h0);
		ce <= 1'h1;
		wreg(A_IDLE, 32'h2);
		wreg(A_MULT, 32'h1);
		wreg(A_MULT, 32'h7);
		rreg(A_MULT, 32'h1);
		$display("test done: reset and registers");
		// slumber without the feature, residency excluded by dipm
		dipm <= 1'h1;
		idle <= 1'h1;
		wait_for(0, 1'h1, n);
		check(n inside {[4 * MS : 5 * MS + 3]}, 1'h1);
		h0 = hours;
		tick(10 * MS);
		check(lnk.sleep_pin, 1'h0);
		check(state, D_SLUMBER);
		check(hours, h0);
		wake <= 1'h1;
		wait_for(2, 1'h1, n);
		wake <= 1'h0;
		idle <= 1'h0;
		dipm <= 1'h0;
		tick();
		check(state, D_ACTIVE);
		$display("test done: slumber without feature");
		// deep sleep with an early wake request
		wreg(A_CTRL, 32'h1);
		tick(2);
		check(feat_en, 1'h1);
		idle <= 1'h1;
		wait_for(1, 1'h1, n);
		tick(2);
		check(state, D_DSLEEP);
		h0 = hours;
		wake <= 1'h1;
		wait_for(1, 1'h0, n);
		check(n >= 10 * MS - 3, 1'h1);
		check(hours, h0);
		check(short_a, 1'h0);
		wait_for(2, 1'h1, n);
		check(n <= 20 * MS + 4, 1'h1);
		wake <= 1'h0;
		idle <= 1'h0;
		check(lnk.sleep_pin, 1'h0);
		// feature off again, multiplier stays locked
		wreg(A_CTRL, 32'h0);
		tick(2);
		check(feat_en, 1'h0);
		rreg(A_STAT, {8'h0, EXIT_TIMEOUT_MS, MIN_ASSERT_MS, 8'h10});
		$display("test done: deep sleep round trip");
		// restored lifetime values and retired blocks
		nv_h <= rnd();
		nv_c <= rnd();
		nv_r <= rnd();
		nv_load <= 1'h1;
		tick();
		nv_load <= 1'h0;
		tick();
		check(cycles, nv_c + 1);
		check(hours, nv_h);
		k = int'(rnd() & 32'h7) + 1;
		for (int i = 0; i < k; i++) begin
			retire <= 1'h1;
			tick();
			retire <= 1'h0;
			tick();
		end
		check(retired, nv_r + k);
		$display("test done: health counters");
		final_report();
	end
endmodule // dslp_bench

// File: verif/dslp_checker.sv
// Purpose: link checks between host and device sleep ends
// Assumes: CE low only while the link is still, MS_CYC cycles per ms
// Notes: feature state is tracked from the command pulses
`timescale 1ns/1ps
module dslp_checker
	import dslp_pkg::*;
#(
	parameter int MS_CYC = 20
) (
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic sleep_pin,
	input wire logic feat_set,
	input wire logic feat_clr,
	input wire logic slumber_req,
	input wire logic slumber_ack,
	input wire logic comwake,
	input wire logic oob_ready,
	input wire logic link_up,
	input wire logic [7:0] min_assert_ms,
	input wire logic [7:0] exit_to_ms
);
	localparam int EXIT_CYC = 20 * MS_CYC + 2;
	localparam int MIN_CYC = 10 * MS_CYC;
	logic feat_q;
	logic feat_d;
	int hold_q;
	int hold_d;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	// feature copy and length of the pin-high stretch
	always_comb begin
		feat_d = feat_set | (feat_q & ~feat_clr);
		hold_d = sleep_pin ? hold_q + 1 : 0;
	end
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			feat_q <= 1'h0;
			hold_q <= 0;
		end else begin
			feat_q <= feat_d;
			hold_q <= hold_d;
		end
	end
	chk_min_report: assert property (min_assert_ms == MIN_ASSERT_MS)
		else $error("minimum assert time report wrong");
	chk_exit_report: assert property (exit_to_ms == EXIT_TIMEOUT_MS)
		else $error("exit timeout report wrong");
	chk_pin_feature: assert property ($rose(sleep_pin) |-> feat_q)
		else $error("sleep pin raised without feature");
	chk_pin_slumber: assert property (sleep_pin |-> slumber_ack)
		else $error("sleep pin high outside slumber");
	chk_ack_follow: assert property ($rose(slumber_req) |=> slumber_ack)
		else $error("slumber request not acknowledged");
	chk_pin_hold: assert property ($fell(sleep_pin) |-> hold_q >= MIN_CYC)
		else $error("sleep pin released too early");
	chk_sleep_entry: assert property ($rose(sleep_pin) && feat_q
		|=> !oob_ready && !link_up)
		else $error("device did not enter deep sleep");
	chk_exit_ready: assert property ($fell(sleep_pin) |->
		!link_up throughout (##[1:EXIT_CYC] oob_ready))
		else $error("device not ready after exit");
	chk_wake_link: assert property (comwake && oob_ready |=> link_up)
		else $error("wake did not bring link up");
	chk_link_cause: assert property ($rose(link_up) |-> $past(comwake))
		else $error("link up without wake");
	cover property ($fell(sleep_pin));
	cover property (comwake && !feat_q);
	cover property ($rose(slumber_ack));
endmodule // dslp_checker
